// ### common/bst_map.svh
/*
 * Constants of the boundary scan test port: instruction codes, register
 * widths, fixed identification value and capture patterns.
 * Assumes it is included by bare name, once per compilation unit.
 */
`ifndef BST_MAP_SVH
`define BST_MAP_SVH

// ----------------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------------
`define BST_IR_W          8
`define BST_IR_EXTEST     8'h00
`define BST_IR_SAMPLE     8'h40
`define BST_IR_IDCODE     8'h55
`define BST_IR_CLAMP      8'hd0
`define BST_IR_HIGHZ      8'h80
`define BST_IR_BYPASS     8'hff
`define BST_IR_CAPTURE    8'h01

// ----------------------------------------------------------------------
// Data registers
// ----------------------------------------------------------------------
`define BST_ID_W          32
// Arbitrary neutral identification value
`define BST_ID_VALUE      32'h1a2b_3c4d
`define BST_CELLS_PER_PIN 3
`define BST_CELL_IN       0
`define BST_CELL_OE       1
`define BST_CELL_OUT      2
`define BST_SYNC_IN       9

`endif

// ### common/bst_pkg.sv
/*
 * Types of the boundary scan test port.
 * Assumes bst_map.svh is available on the include path.
 */
package bst_pkg;

	// ------------------------------------------------------------------
	// Controller states, one-hot
	// ------------------------------------------------------------------
	typedef enum logic [15:0] {
		TAP_RESET     = 16'h0001,
		TAP_IDLE      = 16'h0002,
		TAP_SEL_DR    = 16'h0004,
		TAP_CAP_DR    = 16'h0008,
		TAP_SHIFT_DR  = 16'h0010,
		TAP_EXIT1_DR  = 16'h0020,
		TAP_PAUSE_DR  = 16'h0040,
		TAP_EXIT2_DR  = 16'h0080,
		TAP_UPDATE_DR = 16'h0100,
		TAP_SEL_IR    = 16'h0200,
		TAP_CAP_IR    = 16'h0400,
		TAP_SHIFT_IR  = 16'h0800,
		TAP_EXIT1_IR  = 16'h1000,
		TAP_PAUSE_IR  = 16'h2000,
		TAP_EXIT2_IR  = 16'h4000,
		TAP_UPDATE_IR = 16'h8000
	} bst_state_t;

endpackage : bst_pkg

// ### common/bst_cell_if.sv
/*
 * Link between the port controller and the boundary chain.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface bst_cell_if #(parameter int W = 24);
	logic         capture;
	logic         shift;
	logic         update;
	logic         si;
	logic         so;
	logic [W-1:0] capData;
	logic [W-1:0] latch;

	modport ctrl  (output capture, shift, update, si, capData, input so, latch);
	modport chain (input capture, shift, update, si, capData, output so, latch);
endinterface : bst_cell_if

// ### core/bst_chain.sv
/*
 * Boundary chain: serial shift stage plus parallel output latches.
 * Assumes strobes are single-cycle pulses on ref_clk from the controller.
 */
`timescale 1ns/1ps
module bst_chain #(
	parameter int W = 24
) (
	// Clock and reset
	input wire logic   ref_clk,
	input wire logic   rstn,
	input wire logic   ce,
	// Controller side
	bst_cell_if.chain  cells
);
	import bst_pkg::*;

	logic [W-1:0] shiftReg;
	logic [W-1:0] latchReg;

	// ------------------------------------------------------------------
	// Shift stage, LSB leaves first
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			shiftReg <= '0;
		end else if (ce && cells.capture) begin
			shiftReg <= cells.capData;
		end else if (ce && cells.shift) begin
			shiftReg <= {cells.si, shiftReg[W-1:1]};
		end
	end

	// Parallel latches feed the pins in test modes
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			latchReg <= '0;
		end else if (ce && cells.update) begin
			latchReg <= shiftReg;
		end
	end

	assign cells.so    = shiftReg[0];
	assign cells.latch = latchReg;

endmodule : bst_chain

// ### core/bst_tap.sv
/*
 * Boundary scan test access port: pin synchronisers, controller,
 * instruction, bypass and identification registers, pin multiplexing.
 * Assumes the tester clock is much slower than ref_clk (edges found by
 * sampling) and that pin and core signals are provided per scanned pin.
 */
// How it works
// - Port works only with chip reset high, scan enable high, emulator enable low.
// - Code ff selects bypass; one-bit register between data in and out.
// - Bypass captures zero, so first shifted bit is low, then delayed input.
// - Code 00 selects external test: latches drive pins, pin inputs captured.
// - During external test the output latches drive each pin whose enable cell is set; a pin with its enable cell clear floats.
// - Code 40 selects sample/preload; pins and core pass normally, but open-drain pins with output high drive high.
// - Sample captures pin and core values at capture-DR rising clock.
// - Preload moves shifted data into the parallel output latches on update.
// - Code 55 selects identification; fixed value shifted out LSB first.
// - Entering test-logic-reset loads the identification instruction.
// - Code d0 clamps pins to latched values with bypass in path.
// - While clamping, boundary chain contents are held in every state.
// - Code 80 floats all outputs, holds chain, bypass in path.
// - All serial transfers go least significant bit first.
// - Port unavailable in chip reset, standby or deep standby.
// - Open-drain pin with both cells set drives high in test modes.
// - Supply, clock, reset, control and test pins carry no scan cells.
// - Low test reset reinitialises the instruction register.
// - Instruction register is eight bits; other codes are reserved.
// - Identification register is a fixed read-only 32-bit value.
`timescale 1ns/1ps
`include "bst_map.svh"
module bst_tap #(
	parameter int NUM_PINS = 8
) (
	// Clock, reset, enable
	input wire logic                ref_clk,
	input wire logic                rstn,
	input wire logic                ce,
	// Tester pins
	input wire logic                tck,
	input wire logic                tms,
	input wire logic                tdi,
	input wire logic                trstn,
	output logic                    tdo,
	output logic                    tdoOeN,
	// Chip control pins and power states
	input wire logic                chipResetPin,
	input wire logic                emulatorEnablePin,
	input wire logic                scanEnablePin,
	input wire logic                swStandby,
	input wire logic                deepStandby,
	// Scanned pins, pad side
	input wire logic [NUM_PINS-1:0] pinIn,
	output logic     [NUM_PINS-1:0] pinOut,
	output logic     [NUM_PINS-1:0] pinOeN,
	// Scanned pins, core side
	input wire logic [NUM_PINS-1:0] coreOut,
	input wire logic [NUM_PINS-1:0] coreOe,
	input wire logic [NUM_PINS-1:0] odEnable,
	output logic     [NUM_PINS-1:0] coreIn
);
	import bst_pkg::*;

	localparam int CW = NUM_PINS * `BST_CELLS_PER_PIN;
	localparam int SW = `BST_SYNC_IN + NUM_PINS;

	// ------------------------------------------------------------------
	// Synchronisers for everything from outside the clock domain
	// ------------------------------------------------------------------
	// Edge detection reads only the second stage, never the first
	logic [SW-1:0] syncA;
	logic [SW-1:0] syncB;
	logic          tckPrev;
	wire  [SW-1:0] asyncIn = {pinIn, deepStandby, swStandby, scanEnablePin,
	                          emulatorEnablePin, chipResetPin, trstn, tdi, tms, tck};

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			syncA   <= '0;
			syncB   <= '0;
			tckPrev <= 1'b0;
		end else if (ce) begin
			syncA   <= asyncIn;
			syncB   <= syncA;
			tckPrev <= syncB[0];
		end
	end

	wire                tckS    = syncB[0];
	wire                tmsS    = syncB[1];
	wire                tdiS    = syncB[2];
	wire                trstnS  = syncB[3];
	wire                resPinS = syncB[4];
	wire                emuS    = syncB[5];
	wire                scanS   = syncB[6];
	wire                stbyS   = syncB[7];
	wire                dstbyS  = syncB[8];
	wire [NUM_PINS-1:0] pinInS  = syncB[SW-1:`BST_SYNC_IN];

	// Port enable and test clock edges
	// Dropping any enable or the test reset parks the controller in reset,
	// so a half-finished scan never leaves the pins in a test mode
	wire scanOn  = resPinS & scanS & ~emuS;
	wire portOn  = scanOn & ~stbyS & ~dstbyS;
	wire tapHold = ~portOn | ~trstnS;
	wire tckRise = ce & tckS & ~tckPrev;
	wire tckFall = ce & ~tckS & tckPrev;

	// ------------------------------------------------------------------
	// Controller state machine
	// ------------------------------------------------------------------
	bst_state_t state;
	bst_state_t next_state;

	always_comb begin
		next_state = state;
		case (state)
			TAP_RESET:     next_state = tmsS ? TAP_RESET     : TAP_IDLE;
			TAP_IDLE:      next_state = tmsS ? TAP_SEL_DR    : TAP_IDLE;
			TAP_SEL_DR:    next_state = tmsS ? TAP_SEL_IR    : TAP_CAP_DR;
			TAP_CAP_DR:    next_state = tmsS ? TAP_EXIT1_DR  : TAP_SHIFT_DR;
			TAP_SHIFT_DR:  next_state = tmsS ? TAP_EXIT1_DR  : TAP_SHIFT_DR;
			TAP_EXIT1_DR:  next_state = tmsS ? TAP_UPDATE_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR:  next_state = tmsS ? TAP_EXIT2_DR  : TAP_PAUSE_DR;
			TAP_EXIT2_DR:  next_state = tmsS ? TAP_UPDATE_DR : TAP_SHIFT_DR;
			TAP_UPDATE_DR: next_state = tmsS ? TAP_SEL_DR    : TAP_IDLE;
			TAP_SEL_IR:    next_state = tmsS ? TAP_RESET     : TAP_CAP_IR;
			TAP_CAP_IR:    next_state = tmsS ? TAP_EXIT1_IR  : TAP_SHIFT_IR;
			TAP_SHIFT_IR:  next_state = tmsS ? TAP_EXIT1_IR  : TAP_SHIFT_IR;
			TAP_EXIT1_IR:  next_state = tmsS ? TAP_UPDATE_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR:  next_state = tmsS ? TAP_EXIT2_IR  : TAP_PAUSE_IR;
			TAP_EXIT2_IR:  next_state = tmsS ? TAP_UPDATE_IR : TAP_SHIFT_IR;
			TAP_UPDATE_IR: next_state = tmsS ? TAP_SEL_DR    : TAP_IDLE;
			default:       next_state = TAP_RESET;
		endcase
	end

	// State advances only on a rising test clock
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state <= TAP_RESET;
		end else if (ce && tapHold) begin
			state <= TAP_RESET;
		end else if (tckRise) begin
			state <= next_state;
		end
	end

	wire inReset  = (state == TAP_RESET);
	wire capIr    = (state == TAP_CAP_IR);
	wire shiftIr  = (state == TAP_SHIFT_IR);
	wire updIr    = (state == TAP_UPDATE_IR);
	wire capDr    = (state == TAP_CAP_DR);
	wire shiftDr  = (state == TAP_SHIFT_DR);
	wire updDr    = (state == TAP_UPDATE_DR);

	// ------------------------------------------------------------------
	// Instruction register and decode
	// ------------------------------------------------------------------
	logic [`BST_IR_W-1:0] irShift;
	logic [`BST_IR_W-1:0] instr;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irShift <= `BST_IR_CAPTURE;
		end else if (tckRise && capIr) begin
			irShift <= `BST_IR_CAPTURE;
		end else if (tckRise && shiftIr) begin
			irShift <= {tdiS, irShift[`BST_IR_W-1:1]};
		end
	end

	// Active instruction changes on the falling clock in update-IR
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			instr <= `BST_IR_IDCODE;
		end else if (ce && (tapHold || inReset)) begin
			instr <= `BST_IR_IDCODE;
		end else if (tckFall && updIr) begin
			instr <= irShift;
		end
	end

	// Decoded modes
	wire selExtest  = (instr == `BST_IR_EXTEST);
	wire selSample  = (instr == `BST_IR_SAMPLE);
	wire selIdcode  = (instr == `BST_IR_IDCODE);
	wire selClamp   = (instr == `BST_IR_CLAMP);
	wire selHighz   = (instr == `BST_IR_HIGHZ);
	wire selChain   = selExtest | selSample;
	wire selBypass  = ~(selChain | selIdcode);
	wire testDrive  = selExtest | selClamp;
	wire odOverride = selExtest | selClamp | selSample;

	// ------------------------------------------------------------------
	// Bypass and identification registers
	// ------------------------------------------------------------------
	logic                 bypassBit;
	logic [`BST_ID_W-1:0] idShift;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bypassBit <= 1'b0;
		end else if (tckRise && capDr && selBypass) begin
			bypassBit <= 1'b0;
		end else if (tckRise && shiftDr && selBypass) begin
			bypassBit <= tdiS;
		end
	end

	// Fixed value reloaded on every capture under identification, otherwise only shifted
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			idShift <= `BST_ID_VALUE;
		end else if (tckRise && capDr && selIdcode) begin
			idShift <= `BST_ID_VALUE;
		end else if (tckRise && shiftDr && selIdcode) begin
			idShift <= {tdiS, idShift[`BST_ID_W-1:1]};
		end
	end

	// ------------------------------------------------------------------
	// Boundary chain
	// ------------------------------------------------------------------
	bst_cell_if #(.W(CW)) cells ();
	logic [CW-1:0] capVec;

	// Capture pattern: pin input, enable and data per pin
	// Under external test the enable and data cells read back the latches,
	// which lets the tester confirm what it drove
	genvar k;
	generate
		for (k = 0; k < NUM_PINS; k++) begin : gCap
			assign capVec[k*`BST_CELLS_PER_PIN + `BST_CELL_IN]  = pinInS[k];
			assign capVec[k*`BST_CELLS_PER_PIN + `BST_CELL_OE]  =
				selExtest ? cells.latch[k*`BST_CELLS_PER_PIN + `BST_CELL_OE] : coreOe[k];
			assign capVec[k*`BST_CELLS_PER_PIN + `BST_CELL_OUT] =
				selExtest ? cells.latch[k*`BST_CELLS_PER_PIN + `BST_CELL_OUT] : coreOut[k];
		end
	endgenerate

	// Strobes reach the chain only for chain instructions
	assign cells.capture = tckRise & capDr & selChain;
	assign cells.shift   = tckRise & shiftDr & selChain;
	assign cells.update  = tckFall & updDr & selChain;
	assign cells.si      = tdiS;
	assign cells.capData = capVec;

	bst_chain #(.W(CW)) bst_chain_i (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.ce      (ce),
		.cells   (cells)
	);

	// ------------------------------------------------------------------
	// Serial output, changes on the falling test clock
	// ------------------------------------------------------------------
	// Updating on the falling clock gives the tester half a period of setup
	wire drOut   = selIdcode ? idShift[0] : (selChain ? cells.so : bypassBit);
	wire nextTdo = shiftIr ? irShift[0] : drOut;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			tdo    <= 1'b0;
			tdoOeN <= 1'b1;
		end else if (ce && tapHold) begin
			tdo    <= 1'b0;
			tdoOeN <= 1'b1;
		end else if (tckFall) begin
			tdo    <= nextTdo;
			tdoOeN <= ~(shiftIr | shiftDr);
		end
	end

	// ------------------------------------------------------------------
	// Pin multiplexing, all outputs registered
	// ------------------------------------------------------------------
	logic [NUM_PINS-1:0] next_pinOut;
	logic [NUM_PINS-1:0] next_pinOeN;

	generate
		for (k = 0; k < NUM_PINS; k++) begin : gPin
			wire latOut = cells.latch[k*`BST_CELLS_PER_PIN + `BST_CELL_OUT];
			wire latOe  = cells.latch[k*`BST_CELLS_PER_PIN + `BST_CELL_OE];
			wire odRel  = odEnable[k] & coreOut[k] & ~odOverride;
			assign next_pinOut[k] = testDrive ? latOut : coreOut[k];
			assign next_pinOeN[k] = selHighz  ? 1'b1 :
			                        testDrive ? ~latOe :
			                        (~coreOe[k] | odRel);
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pinOut <= '0;
			pinOeN <= '1;
			coreIn <= '0;
		end else if (ce) begin
			pinOut <= next_pinOut;
			pinOeN <= next_pinOeN;
			coreIn <= pinInS;
		end
	end

endmodule : bst_tap

// ### verification/bst_tap_props.sv
/*
 * Checker of the test port pins: disable conditions, pin pass-through
 * and the timing of the test data output against the test clock.
 * Assumes it is bound by name to bst_tap and that the clock is ref_clk.
 */
`timescale 1ns/1ps
module bst_tap_props #(
	parameter int NUM_PINS = 8
) (
	// Clock and reset
	input wire logic                ref_clk,
	input wire logic                rstn,
	// Link and control pins
	input wire logic                tck,
	input wire logic                trstn,
	input wire logic                tdo,
	input wire logic                tdoOeN,
	input wire logic                chipResetPin,
	input wire logic                emulatorEnablePin,
	input wire logic                scanEnablePin,
	input wire logic                swStandby,
	input wire logic                deepStandby,
	// Scanned pins
	input wire logic [NUM_PINS-1:0] pinIn,
	input wire logic [NUM_PINS-1:0] pinOut,
	input wire logic [NUM_PINS-1:0] pinOeN,
	input wire logic [NUM_PINS-1:0] coreOut,
	input wire logic [NUM_PINS-1:0] coreOe,
	input wire logic [NUM_PINS-1:0] odEnable,
	input wire logic [NUM_PINS-1:0] coreIn
);
	// ------------------------------------------------------------------
	// Shared clocking and steps
	// ------------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	sequence offSeq;
		(!scanEnablePin) [*8];
	endsequence
	sequence tckHighSeq;
		tck [*6];
	endsequence

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	AST_SCAN_OFF: assert property ((!scanEnablePin) [*6] |-> tdoOeN)
		else $error("tdo driven with scan enable low");
	AST_EMUL_OFF: assert property (emulatorEnablePin [*6] |-> tdoOeN)
		else $error("tdo driven with emulator enable high");
	AST_CHIP_RESET: assert property ((!chipResetPin) [*6] |-> tdoOeN)
		else $error("tdo driven in chip reset");
	AST_STANDBY: assert property ((swStandby || deepStandby) [*6] |-> tdoOeN)
		else $error("tdo driven in standby");
	AST_TEST_RESET: assert property ((!trstn) [*6] |-> tdoOeN)
		else $error("tdo driven in test reset");
	AST_PINS_FOLLOW: assert property (offSeq |-> pinOut == $past(coreOut) &&
		pinOeN == ~($past(coreOe) & ~($past(odEnable) & $past(coreOut))))
		else $error("pins do not follow core while port is off");
	AST_CORE_IN: assert property ($stable(pinIn) [*5] |-> coreIn == pinIn)
		else $error("core input does not follow pad");
	AST_TDO_HOLD: assert property (tckHighSeq |-> $stable(tdo) && $stable(tdoOeN))
		else $error("tdo moved while test clock high");
	AST_OUT_AT_FALL: assert property ($changed(tdoOeN) |-> !tck)
		else $error("tdo enable moved outside test clock low");
endmodule : bst_tap_props

// ### verification/bst_tester.sv
/*
 * Tester model: drives test clock, mode, data and test reset, reads tdo.
 * Assumes scans start in Idle or Test-Logic-Reset; clock stands low.
 */
`timescale 1ns/1ps
module bst_tester (
	// Link to the port
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	output logic      trstn,
	input  wire logic tdo,
	input  wire logic tdoOeN
);
	// Idle levels: pulled-up lines high, clock low
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		trstn = 1'b1;
	end

	// One 125 ns period; data out read just before the rise
	task automatic clk1(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#31.25;
		q = tdoOeN ? 1'b1 : tdo; // Released line reads the pull-up
		tck = 1'b1;
		#62.5;
		tck = 1'b0;
		#31.25;
	endtask : clk1

	// Walk to a shift state, shift n bits, update, back to Idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic q;
		dout = '0;
		clk1(1'b0, 1'b1, q);
		clk1(1'b1, 1'b1, q);
		if (ir) begin
			clk1(1'b1, 1'b1, q);
		end
		clk1(1'b0, 1'b1, q);
		clk1(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			clk1(i == n - 1, din[i], q);
			dout[i] = q;
		end
		clk1(1'b1, 1'b1, q);
		clk1(1'b0, 1'b1, q);
	endtask : scan

	// Test reset pulse of one clock period
	task automatic pulse_reset;
		trstn = 1'b0;
		#125;
		trstn = 1'b1;
		#125;
	endtask : pulse_reset
endmodule : bst_tester

// ### verification/bst_tap_bench.sv
/*
 * Bench of the test port: scenarios through the tester model.
 * Assumes package, interface, header and design are compiled first.
 */
`timescale 1ns/1ps
`include "bst_map.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errTotal++; \
	$display("unexpected %s exp %h got %h", nm, ex, got); end end
module bst_tap_bench;
	localparam int         NP = 2;
	localparam logic [4:0] ON = 5'b10100;
	logic          ref_clk, rstn, ce, tck, tms, tdi, trstn, tdo, tdoOeN;
	logic          chipResetPin, emulatorEnablePin, scanEnablePin, swStandby, deepStandby;
	logic [NP-1:0] pinIn, pinOut, pinOeN, coreOut, coreOe, odEnable, coreIn;
	logic [31:0]   rd;
	int            errTotal, compares;

	// ------------------------------------------------------------------
	// Design and tester
	// ------------------------------------------------------------------
	bst_tap #(.NUM_PINS(NP)) bst_tap_i (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
		.tck(tck), .tms(tms), .tdi(tdi), .trstn(trstn), .tdo(tdo), .tdoOeN(tdoOeN),
		.chipResetPin(chipResetPin), .emulatorEnablePin(emulatorEnablePin),
		.scanEnablePin(scanEnablePin), .swStandby(swStandby), .deepStandby(deepStandby),
		.pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN), .coreOut(coreOut),
		.coreOe(coreOe), .odEnable(odEnable), .coreIn(coreIn));
	bst_tester bst_tester_i (.tck(tck), .tms(tms), .tdi(tdi), .trstn(trstn),
		.tdo(tdo), .tdoOeN(tdoOeN));

	// Clock 250 MHz
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	// Control pins and core side, then let synchronisers settle
	task automatic drv(input logic [4:0] en, input logic [NP-1:0] co, oe, od, pi);
		@(posedge ref_clk);
		{chipResetPin, emulatorEnablePin, scanEnablePin, swStandby, deepStandby} <= en;
		coreOut <= co;
		coreOe <= oe;
		odEnable <= od;
		pinIn <= pi;
		repeat (8) @(posedge ref_clk);
	endtask : drv

	// Identification after reset, instruction capture pattern
	task automatic t_id;
		bst_tester_i.scan(1'b0, 32, 32'h0, rd);
		`CHK("id", `BST_ID_VALUE, rd)
		bst_tester_i.scan(1'b1, 8, 32'h55, rd);
		`CHK("ir capture", 32'h01, rd)
	endtask : t_id

	// One-bit path for bypass, reserved, clamp and float codes
	task automatic t_bypass;
		logic [31:0] codes [4] = '{32'hff, 32'h3c, 32'hd0, 32'h80};
		foreach (codes[i]) begin
			bst_tester_i.scan(1'b1, 8, codes[i], rd);
			bst_tester_i.scan(1'b0, 8, 32'ha5, rd);
			`CHK("bypass path", 32'h4a, rd)
		end
	endtask : t_bypass

	// Sample, preload, external test, clamp, float, chain held
	task automatic t_chain;
		drv(ON, 2'b10, 2'b01, 2'b00, 2'b10);
		bst_tester_i.scan(1'b1, 8, 32'h40, rd);
		`CHK("sample pins", 4'b1010, {pinOut, pinOeN})
		bst_tester_i.scan(1'b0, 6, 32'h16, rd);
		`CHK("snapshot", 32'h2a, rd)
		drv(ON, 2'b01, 2'b01, 2'b01, 2'b10);
		`CHK("od sample pins", 4'b0110, {pinOut, pinOeN})
		drv(ON, 2'b10, 2'b01, 2'b01, 2'b10);
		bst_tester_i.scan(1'b1, 8, 32'h00, rd);
		`CHK("extest pins", 4'b0100, {pinOut, pinOeN})
		bst_tester_i.scan(1'b1, 8, 32'hd0, rd);
		`CHK("clamp pins", 4'b0100, {pinOut, pinOeN})
		bst_tester_i.scan(1'b0, 6, 32'h3f, rd);
		bst_tester_i.scan(1'b1, 8, 32'h80, rd);
		`CHK("float oe", 2'b11, pinOeN)
		bst_tester_i.scan(1'b0, 6, 32'h3f, rd);
		bst_tester_i.scan(1'b1, 8, 32'h00, rd);
		bst_tester_i.scan(1'b0, 6, 32'h16, rd);
		`CHK("held chain", 32'h1e, rd)
	endtask : t_chain

	// Each disabling condition in turn returns pins to the core
	task automatic t_off;
		for (int i = 0; i < 5; i++) begin
			drv(ON, 2'b01, 2'b11, 2'b00, 2'b10);
			bst_tester_i.scan(1'b1, 8, 32'h00, rd);
			drv(ON ^ (5'b10000 >> i), 2'b11, 2'b10, 2'b00, 2'b10);
			`CHK("core pins", 5'b11011, {pinOut, pinOeN, tdoOeN})
			drv(ON, 2'b11, 2'b10, 2'b00, 2'b10);
			bst_tester_i.scan(1'b0, 32, 32'h0, rd);
			`CHK("id after off", `BST_ID_VALUE, rd)
		end
	endtask : t_off

	// Test reset pulse drops a loaded instruction
	task automatic t_trst;
		bst_tester_i.scan(1'b1, 8, 32'hff, rd);
		bst_tester_i.pulse_reset();
		bst_tester_i.scan(1'b0, 32, 32'h0, rd);
		`CHK("id after test reset", `BST_ID_VALUE, rd)
	endtask : t_trst

	// Clock enable low: a whole instruction scan is ignored
	task automatic t_ce;
		@(posedge ref_clk);
		ce <= 1'b0;
		bst_tester_i.scan(1'b1, 8, 32'hff, rd);
		`CHK("frozen tdo", 32'hff, rd)
		@(posedge ref_clk);
		ce <= 1'b1;
		repeat (4) @(posedge ref_clk);
		bst_tester_i.scan(1'b0, 32, 32'h0, rd);
		`CHK("id after freeze", `BST_ID_VALUE, rd)
	endtask : t_ce

	// Verdict and end of run
	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, errTotal);
		if (errTotal == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run

	// ------------------------------------------------------------------
	// Sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		{chipResetPin, emulatorEnablePin, scanEnablePin, swStandby, deepStandby} = ON;
		coreOut = '0;
		coreOe = '0;
		odEnable = '0;
		pinIn = '0;
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (8) @(posedge ref_clk);
		t_id();
		t_bypass();
		t_chain();
		t_off();
		t_trst();
		t_ce();
		complete_run();
	end

	// Cut a hang well past the expected run length
	initial begin
		#300000;
		errTotal++;
		complete_run();
	end
endmodule : bst_tap_bench

bind bst_tap bst_tap_props #(.NUM_PINS(NUM_PINS)) bst_tap_props_i (.ref_clk, .rstn,
	.tck, .trstn, .tdo, .tdoOeN, .chipResetPin, .emulatorEnablePin, .scanEnablePin,
	.swStandby, .deepStandby, .pinIn, .pinOut, .pinOeN, .coreOut, .coreOe,
	.odEnable, .coreIn);
